/* logic/lsf_break_det.sv */
// Break detector: one pulse per unbroken low stretch of a full frame.
module lsf_break_det
    import lsf_pkg::*;
#(
    parameter int FRAME_CYCLES = LSF_FRAME_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic rx_line,
    output logic brk_pulse
);

    localparam int CW = $clog2(FRAME_CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic done;
        logic pulse;
    } lsf_brk_state_t;

    lsf_brk_state_t s_reg;
    lsf_brk_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.pulse = 1'b0;
        if (rx_line) begin
            s_next.cnt = '0;
            s_next.done = 1'b0;
        end else if (!s_reg.done) begin
            if (s_reg.cnt == CW'(FRAME_CYCLES - 1)) begin
                // Rearm only on a high line, so one pulse per break
                s_next.done = 1'b1;
                s_next.pulse = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign brk_pulse = s_reg.pulse;

    a_brk_single: assert property (
        @(posedge ref_clk) disable iff (rst)
        brk_pulse |=> !brk_pulse [*8])
        else $error("break pulse repeated within one low stretch");

    a_brk_after_low: assert property (
        @(posedge ref_clk) disable iff (rst)
        brk_pulse |-> !$past(rx_line) && s_reg.done)
        else $error("break pulse without a low line");

endmodule : lsf_break_det

/* logic/lsf_line_status.sv */
// Receive storage with per-entry error flags and the line status register.
module lsf_line_status
    import lsf_pkg::*;
#(
    parameter int FIFO_DEPTH = LSF_FIFO_DEPTH,
    parameter int FRAME_CYCLES = LSF_FRAME_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire lsf_bus_req_t bus,
    output logic [7:0] rd_data,
    input wire lsf_rx_char_t rx_char,
    input wire logic rx_line,
    output logic rx_full
);

    localparam int AW = $clog2(FIFO_DEPTH);
    localparam int CW = AW + 1;

    typedef struct packed {
        lsf_entry_t [FIFO_DEPTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] count;
        logic [CW-1:0] err_count;
        logic head_seen;
        logic overrun;
        logic fifo_en;
        logic [7:0] rdata;
    } lsf_state_t;

    lsf_state_t s_reg;
    lsf_state_t s_next;
    logic brk_pulse;
    logic [CW-1:0] cap;
    logic push_req;
    logic pop;
    logic push;
    logic ovr_evt;
    logic ls_read;
    logic head_vis;
    lsf_entry_t head;
    lsf_entry_t new_entry;
    logic [7:0] ls_val;

    lsf_break_det #(
        .FRAME_CYCLES(FRAME_CYCLES)
    ) u_brk (
        .ref_clk(ref_clk),
        .rst(rst),
        .rx_line(rx_line),
        .brk_pulse(brk_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status view and storage control
    always_comb begin
        cap = s_reg.fifo_en ? CW'(FIFO_DEPTH) : CW'(1);
        rx_full = (s_reg.count >= cap);
        head = s_reg.mem[s_reg.rp];
        head_vis = (s_reg.count != '0) && !s_reg.head_seen;
        // A break frame replaces the receiver's own character of that cycle
        push_req = brk_pulse || rx_char.valid;
        if (brk_pulse) begin
            new_entry = '{brk: 1'b1, frm: 1'b0, par: 1'b0,
                          data: LSF_BREAK_CHAR};
        end else begin
            new_entry = '{brk: 1'b0, frm: rx_char.stop_bad,
                          par: rx_char.parity_bad,
                          data: rx_char.data};
        end
        pop = bus.rd && (bus.addr == LSF_ADDR_RX_DATA) &&
              (s_reg.count != '0);
        ls_read = bus.rd && (bus.addr == LSF_ADDR_LINE_STATUS);
        // A read in the same cycle frees a slot, so no overrun then
        ovr_evt = push_req && rx_full && !pop;
        push = push_req && !ovr_evt;
        ls_val = '0;
        ls_val[LSF_LS_DATA_READY] = (s_reg.count != '0);
        ls_val[LSF_LS_OVERRUN] = s_reg.overrun;
        ls_val[LSF_LS_PARITY] = head_vis && head.par;
        ls_val[LSF_LS_FRAMING] = head_vis && head.frm;
        ls_val[LSF_LS_BREAK] = head_vis && head.brk;
        ls_val[LSF_LS_FIFO_ERR] = s_reg.fifo_en &&
                                  (s_reg.err_count != '0);
    end

    always_comb begin
        s_next = s_reg;
        s_next.rdata = '0;
        if (bus.rd) begin
            unique case (bus.addr)
                LSF_ADDR_RX_DATA: s_next.rdata = head_vis || pop ?
                                                 head.data : 8'h00;
                LSF_ADDR_CTRL: s_next.rdata = {7'h00, s_reg.fifo_en};
                LSF_ADDR_LINE_STATUS: s_next.rdata = ls_val;
                default: s_next.rdata = 8'h00;
            endcase
        end
        // Error flags clear on a status read; new events win below
        if (ls_read) begin
            s_next.overrun = 1'b0;
            // Nothing to mark on empty storage, so the next arrival shows
            s_next.head_seen = (s_reg.count != '0);
        end
        if (ovr_evt) begin
            s_next.overrun = 1'b1;
        end
        if (push) begin
            s_next.mem[s_reg.wp] = new_entry;
            s_next.wp = s_reg.wp + AW'(1);
        end
        if (pop) begin
            // A fresh head shows its flags again
            s_next.rp = s_reg.rp + AW'(1);
            s_next.head_seen = 1'b0;
        end
        s_next.count = s_reg.count + CW'(push) - CW'(pop);
        s_next.err_count = s_reg.err_count +
            CW'(push && (new_entry.brk || new_entry.frm || new_entry.par)) -
            CW'(pop && (head.brk || head.frm || head.par));
        // Changing the mode flushes storage, as the depth changes under it
        if (bus.wr && (bus.addr == LSF_ADDR_CTRL) &&
            (bus.wdata[LSF_CTRL_FIFO_EN] != s_reg.fifo_en)) begin
            s_next.fifo_en = bus.wdata[LSF_CTRL_FIFO_EN];
            s_next.wp = '0;
            s_next.rp = '0;
            s_next.count = '0;
            s_next.err_count = '0;
            s_next.head_seen = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.fifo_en <= LSF_FIFO_EN_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rd_data = s_reg.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_ovr_sets_flag: assert property (
        @(posedge ref_clk) disable iff (rst)
        rx_char.valid && rx_full && !pop |=> ls_val[LSF_LS_OVERRUN])
        else $error("overrun flag not set on full storage");

    a_ovr_keeps_fifo: assert property (
        @(posedge ref_clk) disable iff (rst)
        push_req && rx_full && !pop && !bus.wr |=>
        s_reg.count == $past(s_reg.count) &&
        s_reg.wp == $past(s_reg.wp))
        else $error("storage changed on overrun");

    a_ready_after_push: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_reg.count == '0 && push && !bus.wr |=> ls_val[LSF_LS_DATA_READY])
        else $error("data ready missing after a character");

    // A break into empty storage becomes the head at once
    a_break_reported: assert property (
        @(posedge ref_clk) disable iff (rst)
        brk_pulse && s_reg.count == '0 && !bus.wr |=>
        ls_val[LSF_LS_BREAK])
        else $error("break not shown for break character");

    // Flags of a character landing in empty storage show at once
    a_frame_head: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_reg.count == '0 && rx_char.valid && !brk_pulse && !bus.wr |=>
        ls_val[LSF_LS_FRAMING] == $past(rx_char.stop_bad))
        else $error("framing flag does not follow head entry");

    a_parity_head: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_reg.count == '0 && rx_char.valid && !brk_pulse && !bus.wr |=>
        ls_val[LSF_LS_PARITY] == $past(rx_char.parity_bad))
        else $error("parity flag does not follow head entry");

    // An arrival into empty storage in the read cycle keeps its flags
    a_read_clears: assert property (
        @(posedge ref_clk) disable iff (rst)
        ls_read && !ovr_evt && !pop && !(push && s_reg.count == '0) |=>
        !ls_val[LSF_LS_OVERRUN] && !ls_val[LSF_LS_BREAK] &&
        !ls_val[LSF_LS_FRAMING] && !ls_val[LSF_LS_PARITY])
        else $error("status read did not clear error flags");

    a_err_summary: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_reg.fifo_en && push && !bus.wr &&
        (new_entry.brk || new_entry.frm || new_entry.par) |=>
        ls_val[LSF_LS_FIFO_ERR])
        else $error("error summary missing with error entry stored");

    a_reset_clear: assert property (
        @(posedge ref_clk) rst |=> ls_val[4:0] == 5'h00)
        else $error("status bits not cleared by reset");

endmodule : lsf_line_status

/* logic/lsf_pkg.sv */
// Constants and carrier types for the receive line status block.
// Function
// - Set break flag, bit 4, after the line stays low a whole frame.
// - In FIFO mode a break loads exactly one break character.
// - Set framing error, bit 3, when the stop bit is invalid.
// - In FIFO mode framing and parity flags follow the FIFO head entry.
// - Set parity error, bit 2, when received parity mismatches setting.
// - Set overrun, bit 1, when a character completes while FIFO is full.
// - On overrun the new character is dropped; FIFO contents stay intact.
// - Bit 0 is high while any received character waits unread.
// - In FIFO mode bit 7 is high while any stored entry carries an error; outside FIFO mode it stays low.
// - Reset clears status bits 4 down to 0.
package lsf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes and timing
    localparam int LSF_FIFO_DEPTH = 16;
    localparam int LSF_FRAME_CYCLES = 1000;

    ////////////////////////////////////////////////////////////////////////
    // Register map, address port is two bits wide
    localparam logic [1:0] LSF_ADDR_RX_DATA = 2'h0;
    localparam logic [1:0] LSF_ADDR_CTRL = 2'h1;
    localparam logic [1:0] LSF_ADDR_LINE_STATUS = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int LSF_LS_DATA_READY = 0;
    localparam int LSF_LS_OVERRUN = 1;
    localparam int LSF_LS_PARITY = 2;
    localparam int LSF_LS_FRAMING = 3;
    localparam int LSF_LS_BREAK = 4;
    localparam int LSF_LS_FIFO_ERR = 7;
    localparam int LSF_CTRL_FIFO_EN = 0;
    localparam logic LSF_FIFO_EN_RST = 1'b0;
    localparam logic [7:0] LSF_BREAK_CHAR = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lsf_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic parity_bad;
        logic stop_bad;
    } lsf_rx_char_t;

    typedef struct packed {
        logic brk;
        logic frm;
        logic par;
        logic [7:0] data;
    } lsf_entry_t;

endpackage : lsf_pkg

/* sim/lsf_line_status_test.sv */
// Self-checking bench for the receive line status block.
module lsf_line_status_test
    import lsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 16;
    localparam int FRAME = 20;
    localparam logic [1:0] st_a = LSF_ADDR_LINE_STATUS;
    localparam logic [1:0] dt_a = LSF_ADDR_RX_DATA;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    lsf_bus_req_t bus = '0;
    logic [7:0] rd_data;
    lsf_rx_char_t rx_char;
    logic rx_line;
    logic rx_full;
    logic rd_q = 1'b0;
    int failures = 0;
    int checks = 0;
    int seed = 32'hf0bd_cdeb;
    logic [7:0] exp_q[$];
    string nm_q[$];
    logic [7:0] held[$];
    logic [7:0] d;

    lsf_line_status #(.FIFO_DEPTH(DEPTH), .FRAME_CYCLES(FRAME)) dut (
        .ref_clk(ref_clk), .rst(rst), .bus(bus), .rd_data(rd_data),
        .rx_char(rx_char), .rx_line(rx_line), .rx_full(rx_full));
    lsf_rx_partner rxm (.ref_clk(ref_clk), .rx_char(rx_char),
        .rx_line(rx_line));

    initial forever #5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [7:0] st(input logic dr, input logic ov,
        input logic pe, input logic fe, input logic bk, input logic fx);
        logic [7:0] v;
        v = 8'h00;
        v[LSF_LS_DATA_READY] = dr;
        v[LSF_LS_OVERRUN] = ov;
        v[LSF_LS_PARITY] = pe;
        v[LSF_LS_FRAMING] = fe;
        v[LSF_LS_BREAK] = bk;
        v[LSF_LS_FIFO_ERR] = fx;
        return v;
    endfunction : st

    task automatic cmp(input string nm, input logic [7:0] ex,
        input logic [7:0] got);
        checks++;
        if (got !== ex) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp

    task automatic cmp_full(input logic ex, input logic got);
        checks++;
        if (got !== ex) begin
            failures++;
            $display("wrong value rx_full expected %b seen %b", ex, got);
        end
    endtask : cmp_full

    task automatic conclude();
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // Strobe drops at the next edge; the following call waits one more
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] ex,
        input string nm);
        exp_q.push_back(ex);
        nm_q.push_back(nm);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_q && exp_q.size() > 0) begin
            cmp(nm_q.pop_front(), exp_q.pop_front(), rd_data);
        end
        rd_q <= bus.rd;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        $display("wrong value timeout expected 1 seen 0");
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(st_a, st(0, 0, 0, 0, 0, 0), "status");
        rd(2'h3, 8'h00, "unmapped");
        rxm.send(8'h41, 1'b0, 1'b0);
        rd(st_a, st(1, 0, 0, 0, 0, 0), "status");
        rd(dt_a, 8'h41, "data");
        rd(st_a, st(0, 0, 0, 0, 0, 0), "status");
        rxm.send(8'h11, 1'b0, 1'b0);
        rxm.send(8'h22, 1'b0, 1'b0);
        rd(st_a, st(1, 1, 0, 0, 0, 0), "status");
        rd(dt_a, 8'h11, "data");
        rd(st_a, st(0, 0, 0, 0, 0, 0), "status");
        wr(LSF_ADDR_CTRL, 8'h01);
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            held.push_back(d);
            rxm.send(d, i == 0, i == 1);
        end
        rd(st_a, st(1, 0, 1, 0, 0, 1), "status");
        rd(dt_a, held[0], "data");
        rd(st_a, st(1, 0, 0, 1, 0, 1), "status");
        rd(dt_a, held[1], "data");
        rd(st_a, st(1, 0, 0, 0, 0, 0), "status");
        rd(dt_a, held[2], "data");
        held.delete();
        for (int i = 0; i < DEPTH; i++) begin
            d = 8'($random(seed));
            held.push_back(d);
            rxm.send(d, 1'b0, 1'b0);
        end
        @(negedge ref_clk);
        cmp_full(1'b1, rx_full);
        rxm.send(8'h5a, 1'b0, 1'b0);
        rd(st_a, st(1, 1, 0, 0, 0, 0), "status");
        foreach (held[i]) rd(dt_a, held[i], "data");
        rd(st_a, st(0, 0, 0, 0, 0, 0), "status");
        rxm.low(FRAME / 2);
        repeat (5) @(posedge ref_clk);
        rd(st_a, st(0, 0, 0, 0, 0, 0), "status");
        rxm.low(FRAME + 10);
        repeat (5) @(posedge ref_clk);
        rd(st_a, st(1, 0, 0, 0, 1, 1), "status");
        rd(dt_a, LSF_BREAK_CHAR, "data");
        rd(st_a, st(0, 0, 0, 0, 0, 0), "status");
        // Mid-run reset with a flagged character stored must clear all
        rxm.send(8'h7e, 1'b1, 1'b1);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(st_a, st(0, 0, 0, 0, 0, 0), "status");
        rd(LSF_ADDR_CTRL, 8'h00, "ctrl");
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) begin
            @(posedge ref_clk);
        end
        if (exp_q.size() > 0) begin
            failures++;
            $display("wrong value pending expected 0 seen %0d", exp_q.size());
        end
        conclude();
    end
endmodule : lsf_line_status_test

/* sim/lsf_rx_partner.sv */
// Behavioural receiver front end that feeds characters and line levels.
module lsf_rx_partner
    import lsf_pkg::*;
(
    input wire logic ref_clk,
    output lsf_rx_char_t rx_char,
    output logic rx_line
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rx_char = '0;
        rx_line = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Fields outside a valid pulse show inverted junk, never stale data
    task automatic send(input logic [7:0] d, input logic p, input logic s);
        @(posedge ref_clk);
        rx_char <= '{valid: 1'b1, data: d, parity_bad: p, stop_bad: s};
        @(posedge ref_clk);
        rx_char <= '{valid: 1'b0, data: ~d, parity_bad: ~p, stop_bad: ~s};
    endtask : send

    task automatic low(input int n);
        @(posedge ref_clk);
        rx_line <= 1'b0;
        repeat (n) @(posedge ref_clk);
        rx_line <= 1'b1;
    endtask : low
endmodule : lsf_rx_partner
